// ### oe_cfg_pkg.sv
// Package of constants for the serial output enable configuration slave.
package oe_cfg_pkg;
   // ==========================================================
   // Bus address and framing
   localparam logic [6:0] SLAVE_ADDR = 7'h69;
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
   localparam int BYTE_BITS = 8;
   // Bytes that lead every block write: command code and byte count.
   localparam int HEADER_BYTES = 2;
   // ==========================================================
   // Register layout
   localparam int OE_LSB = 0;
   localparam int OE_MSB = 3;
   localparam int OE_COUNT = 4;
   localparam logic [7:0] OE_GROUP_A_RESET = 8'h0F;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int HOLD_LIMIT_MS = 10;
   localparam int HOLD_LIMIT_CYCLES = HOLD_LIMIT_MS * 1000 * CLK_MHZ;
endpackage

// ### oe_cfg_if.sv
// Interface carrying sampled bus events from the pin front end to the core.
`timescale 1ns/100ps
interface oe_cfg_if;
   logic start;
   logic stop;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   modport front(output start, output stop, output scl_rise,
      output scl_fall, output sda);
   modport core(input start, input stop, input scl_rise,
      input scl_fall, input sda);
endinterface

// ### oe_cfg_pins.sv
// Pin synchroniser and bus condition detector for the serial link.
`timescale 1ns/100ps
module oe_cfg_pins (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   oe_cfg_if.front ev
);
   // ==========================================================
   // Two-stage synchronisers, then a third stage for edge history.
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   assign ev.sda = sda_sync_q[1];
   assign ev.scl_rise = scl_sync_q[1] & ~scl_prev_q;
   assign ev.scl_fall = ~scl_sync_q[1] & scl_prev_q;
   assign ev.start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
   assign ev.stop = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
endmodule

// ### oe_cfg_slave.sv
// Serial write-only configuration slave driving clock output enables.
//
// Notes on behaviour
// - Answer only address 1101001, with read or write.
// - Only writes exist; direction bit not decoded.
// - Slave receiver only, never transmits data.
// - Standard 100 kbit/s rate supported, fast optional.
// - Data bytes ascending from zero; stop anywhere.
// - Acknowledge every received byte.
// - Transfer valid once count byte acknowledged.
// - Command and count bytes are discarded.
// - Bytes beyond implemented ones are discarded.
// - Never hold data low beyond 10 ms.
// - General call address is ignored.
// - No glitch filter on bus inputs.
// - Power-down releases pins, keeps configuration.
// - Bytes in order, bit 7 first.
// - Reserved bits ignored, host writes zero.
// - Register holds last written value.
// - Byte 0 bits 3..0 enable outputs 3..0.
// - Disabled output forced low, stops switching.
`timescale 1ns/100ps
module oe_cfg_slave #(
   parameter int HOLD_LIMIT = oe_cfg_pkg::HOLD_LIMIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   input wire logic power_down_mode,
   input wire logic [oe_cfg_pkg::OE_COUNT-1:0] clk_in,
   output logic [oe_cfg_pkg::OE_COUNT-1:0] clk_out,
   output logic [7:0] output_enable_group_a,
   output logic transfer_valid
);
   // ==========================================================
   // Front end
   oe_cfg_if ev();
   logic pd_meta_q;
   logic pd_q;
   logic [oe_cfg_pkg::OE_COUNT-1:0] clk_meta_q;
   logic [oe_cfg_pkg::OE_COUNT-1:0] clk_sync_q;

   // Raw pins go straight to the synchroniser with no filter.
   oe_cfg_pins u_pins (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .scl_in(serial_clock_pin_in),
      .sda_in(serial_data_pin_in),
      .ev(ev)
   );

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pd_meta_q <= 1'b0;
         pd_q <= 1'b0;
      end else begin
         pd_meta_q <= power_down_mode;
         pd_q <= pd_meta_q;
      end
   end

   // ==========================================================
   // Protocol state machine
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_DATA = 3'b011,
      ST_DATA_ACK = 3'b100,
      ST_IGNORE = 3'b101
   } state_t;

   state_t state_q, state_d;
   logic [2:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [5:0] byte_idx_q, byte_idx_d;
   logic ack_drive_q, ack_drive_d;
   logic [7:0] reg_a_q, reg_a_d;
   logic valid_q, valid_d;
   logic [31:0] hold_cnt_q;
   logic hold_expired;

   wire logic [7:0] byte_now = {shift_q[6:0], ev.sda};
   wire logic last_bit = (bit_cnt_q == 3'h7);
   // The direction bit is not decoded; only the address bits matter.
   wire logic addr_hit =
      (byte_now[7:1] == oe_cfg_pkg::SLAVE_ADDR);
   wire logic data_byte_slot =
      (byte_idx_q == 6'(oe_cfg_pkg::HEADER_BYTES));

   // Bit stream shifts in MSB first on each rising clock edge.
   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      byte_idx_d = byte_idx_q;
      ack_drive_d = ack_drive_q;
      reg_a_d = reg_a_q;
      valid_d = valid_q;
      if (pd_q || hold_expired) begin
         state_d = ST_IDLE;
         ack_drive_d = 1'b0;
      end else if (ev.start) begin
         state_d = ST_ADDR;
         bit_cnt_d = 3'h0;
         byte_idx_d = 6'h00;
         ack_drive_d = 1'b0;
         valid_d = 1'b0;
      end else if (ev.stop) begin
         state_d = ST_IDLE;
         ack_drive_d = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE, ST_IGNORE: begin
               ack_drive_d = 1'b0;
            end
            ST_ADDR, ST_DATA: begin
               if (ev.scl_rise) begin
                  shift_d = byte_now;
                  bit_cnt_d = bit_cnt_q + 3'h1;
               end
               if (ev.scl_rise && last_bit) begin
                  if (state_q == ST_ADDR) begin
                     state_d = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
                  end else begin
                     state_d = ST_DATA_ACK;
                     if (data_byte_slot) begin
                        reg_a_d = byte_now;
                     end
                  end
               end
            end
            ST_ADDR_ACK, ST_DATA_ACK: begin
               // Drive low from the fall after bit 0 to the next fall.
               if (ev.scl_fall) begin
                  if (!ack_drive_q) begin
                     ack_drive_d = 1'b1;
                  end else begin
                     ack_drive_d = 1'b0;
                     state_d = ST_DATA;
                     bit_cnt_d = 3'h0;
                     if (state_q == ST_DATA_ACK) begin
                        if (byte_idx_q < 6'h3F) begin
                           byte_idx_d = byte_idx_q + 6'h01;
                        end
                        if (byte_idx_q == 6'h01) begin
                           valid_d = 1'b1;
                        end
                     end
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
               ack_drive_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 3'h0;
         shift_q <= 8'h00;
         byte_idx_q <= 6'h00;
         ack_drive_q <= 1'b0;
         reg_a_q <= oe_cfg_pkg::OE_GROUP_A_RESET;
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         byte_idx_q <= byte_idx_d;
         ack_drive_q <= ack_drive_d;
         reg_a_q <= reg_a_d;
         valid_q <= valid_d;
      end
   end

   // ==========================================================
   // Watchdog on the data line hold.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hold_cnt_q <= 32'h0;
      end else if (ack_drive_q) begin
         hold_cnt_q <= hold_cnt_q + 32'h1;
      end else begin
         hold_cnt_q <= 32'h0;
      end
   end

   assign hold_expired = (hold_cnt_q >= 32'(HOLD_LIMIT - 1));

   // ==========================================================
   // Pins: the clock line is never driven, and no data is sent.
   assign serial_clock_pin_out = 1'b0;
   assign serial_clock_pin_oe = 1'b0;
   assign serial_data_pin_out = 1'b0;
   assign serial_data_pin_oe = ack_drive_q & ~pd_q;

   // ==========================================================
   // Output gating, held low while disabled.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         clk_meta_q <= '0;
         clk_sync_q <= '0;
      end else begin
         clk_meta_q <= clk_in;
         clk_sync_q <= clk_meta_q;
      end
   end

   generate
      for (genvar i = 0; i < oe_cfg_pkg::OE_COUNT; i++) begin : g_gate
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               clk_out[i] <= 1'b0;
            end else begin
               clk_out[i] <= clk_sync_q[i] &
                  reg_a_q[oe_cfg_pkg::OE_LSB + i];
            end
         end
      end
   endgenerate

   // Upper bits are stored as written but steer nothing.
   assign output_enable_group_a = reg_a_q;
   assign transfer_valid = valid_q;
endmodule

// ### oe_cfg_checker.sv
// Checker for the output enable configuration slave ports.
`timescale 1ns/100ps
module oe_cfg_checker #(
   parameter int HOLD_LIMIT = oe_cfg_pkg::HOLD_LIMIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic serial_clock_pin_in,
   input wire logic serial_clock_pin_out,
   input wire logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe,
   input wire logic power_down_mode,
   input wire logic [3:0] clk_in,
   input wire logic [3:0] clk_out,
   input wire logic [7:0] output_enable_group_a,
   input wire logic transfer_valid
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [31:0] hold_q;
   logic [31:0] hold_d;
   assign hold_d = serial_data_pin_oe ? hold_q + 32'h1 : 32'h0;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) hold_q <= 32'h0;
      else hold_q <= hold_d;
   end
   sequence ack_held;
      serial_data_pin_oe [*4];
   endsequence
   chk_clock_not_held: assert property (!serial_clock_pin_oe)
      else $error("bus clock line driven");
   chk_data_low_only: assert property (!serial_data_pin_out)
      else $error("data line driven high");
   chk_hold_bounded: assert property (hold_q <= HOLD_LIMIT)
      else $error("data line held too long");
   chk_ack_in_low: assert property ($rose(serial_data_pin_oe) |->
      !serial_clock_pin_in) else $error("ack started with clock high");
   chk_ack_held: assert property (serial_data_pin_oe &&
      $rose(serial_clock_pin_in) |=> ack_held) else $error("ack dropped");
   chk_pd_release: assert property (power_down_mode [*4] |->
      !serial_data_pin_oe) else $error("pin driven in power down");
   chk_pd_keeps: assert property (power_down_mode [*4] |=>
      $stable(output_enable_group_a)) else $error("config lost");
   chk_cfg_after_valid: assert property (
      $changed(output_enable_group_a) |-> transfer_valid)
      else $error("config changed without valid");
   chk_gate_off: assert property (
      (clk_out & ~output_enable_group_a[3:0]
      & ~$past(output_enable_group_a[3:0])) == 4'h0)
      else $error("disabled output switching");
endmodule
bind oe_cfg_slave oe_cfg_checker #(.HOLD_LIMIT(HOLD_LIMIT)) chk_u (
   .sys_clk(sys_clk), .resetn(resetn),
   .serial_clock_pin_in(serial_clock_pin_in),
   .serial_clock_pin_out(serial_clock_pin_out),
   .serial_clock_pin_oe(serial_clock_pin_oe),
   .serial_data_pin_in(serial_data_pin_in),
   .serial_data_pin_out(serial_data_pin_out),
   .serial_data_pin_oe(serial_data_pin_oe),
   .power_down_mode(power_down_mode), .clk_in(clk_in), .clk_out(clk_out),
   .output_enable_group_a(output_enable_group_a),
   .transfer_valid(transfer_valid));

// ### oe_cfg_host.sv
// Behavioural bus controller that issues block writes.
`timescale 1ns/100ps
module oe_cfg_host (
   output logic scl,
   output logic sda,
   input wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task start();
      sda = 1'b0;
      #40 scl = 1'b0;
   endtask
   // Bits go out MSB first on an 80 ns bus clock; ack is read mid-high.
   task put_byte(input logic [7:0] b, output logic ack);
      stall_byte(b, 20, ack);
   endtask
   // Same byte, with the clock held low for 20 ns plus hold_ns before the ack pulse.
   task stall_byte(input logic [7:0] b, input int hold_ns,
      output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #20 sda = b[i];
         #20 scl = 1'b1;
         #40 scl = 1'b0;
      end
      #20 sda = 1'b1;
      #(hold_ns) scl = 1'b1;
      #20 ack = !sda_line;
      #20 scl = 1'b0;
   endtask
   task stop();
      #20 sda = 1'b0;
      #20 scl = 1'b1;
      #40 sda = 1'b1;
      #80;
   endtask
endmodule

// ### serial_output_enable_config_test.sv
// Self-checking bench for the output enable configuration slave.
`timescale 1ns/100ps
module serial_output_enable_config_test;
   typedef struct {logic [7:0] addr; logic [7:0] data; logic ack;
      logic [7:0] cfg;} row_t;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic pd = 1'b0;
   logic [3:0] clk_in = 4'h0;
   logic scl_h, sda_h, scl_oe, sda_oe, valid;
   logic [3:0] clk_out;
   logic [7:0] cfg, acks;
   wire scl_line = scl_h & ~scl_oe;
   wire sda_line = sda_h & ~sda_oe;
   int n_fail = 0;
   int check_count = 0;
   row_t rows[6] = '{'{8'hD2, 8'h05, 1'b1, 8'h05},
      '{8'hD2, 8'h0A, 1'b1, 8'h0A}, '{8'hD2, 8'h03, 1'b1, 8'h03},
      '{8'h00, 8'h00, 1'b0, 8'h03}, '{8'hD4, 8'h00, 1'b0, 8'h03},
      '{8'hD2, 8'h00, 1'b1, 8'h00}};
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) clk_in <= #1 clk_in + 4'h1;
   oe_cfg_host host_u (.scl(scl_h), .sda(sda_h), .sda_line(sda_line));
   oe_cfg_slave #(.HOLD_LIMIT(2000)) dut_u (.sys_clk(sys_clk),
      .resetn(resetn), .serial_clock_pin_in(scl_line),
      .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe),
      .serial_data_pin_in(sda_line), .serial_data_pin_out(),
      .serial_data_pin_oe(sda_oe), .power_down_mode(pd), .clk_in(clk_in),
      .clk_out(clk_out), .output_enable_group_a(cfg),
      .transfer_valid(valid));
   task check_byte(input string name, input logic [7:0] exp, got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task check_bit(input string name, input logic exp, got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask
   // Bit 0 of the ack mask belongs to the address byte.
   task xfer(input logic [7:0] addr, input logic [7:0] q[$]);
      logic a;
      host_u.start();
      host_u.put_byte(addr, a);
      acks = {7'h0, a};
      foreach (q[i]) begin
         host_u.put_byte(q[i], a);
         acks[i + 1] = a;
      end
      host_u.stop();
   endtask
   task check_clocks(input logic [3:0] exp);
      logic [3:0] seen;
      seen = 4'h0;
      repeat (24) @(negedge sys_clk) seen |= clk_out;
      check_byte("clock activity", {4'h0, exp}, {4'h0, seen});
      // Leaves the caller one step after a rising edge.
      @(posedge sys_clk) #1;
   endtask
   task give_verdict();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #300000;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge sys_clk);
      check_byte("reset config", 8'h0F, cfg);
      check_bit("reset valid", 1'b0, valid);
      check_clocks(4'hF);
      foreach (rows[i]) begin
         xfer(rows[i].addr, {8'h00, 8'h01, rows[i].data});
         check_byte("acks", rows[i].ack ? 8'h0F : 8'h00, acks);
         check_bit("valid", rows[i].ack, valid);
         check_byte("config", rows[i].cfg, cfg);
         check_clocks(rows[i].cfg[3:0]);
      end
      xfer(8'hD2, {8'h00, 8'h03, 8'h06, 8'hF0, 8'hC0});
      check_byte("long acks", 8'h3F, acks);
      check_byte("long config", 8'h06, cfg);
      xfer(8'hD2, {8'h00});
      check_bit("short valid", 1'b0, valid);
      check_byte("short config", 8'h06, cfg);
      pd = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      xfer(8'hD2, {8'h00, 8'h01, 8'h0F});
      check_byte("pd acks", 8'h00, acks);
      check_byte("pd config", 8'h06, cfg);
      pd = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      host_u.start();
      host_u.stall_byte(8'hD2, 25000, acks[0]);
      host_u.stop();
      check_bit("stall ack", 1'b0, acks[0]);
      xfer(8'hD2, {8'h00, 8'h01, 8'h09});
      check_byte("final config", 8'h09, cfg);
      check_clocks(4'h9);
      resetn = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check_byte("mid reset config", 8'h0F, cfg);
      check_bit("mid reset valid", 1'b0, valid);
      check_clocks(4'hF);
      give_verdict();
   end
endmodule
